// >>> pkg/dac_port_defs.vh
// Constants of the serial D/A and expander command port.
// Assumes inclusion by bare name from design files only.
`ifndef DAC_PORT_DEFS_VH
`define DAC_PORT_DEFS_VH
`define FRAME_BITS       16
`define CNT_W            5
`define FUNC_LSB         0
`define FUNC_MSB         3
`define PAYLOAD_LSB      4
`define PAYLOAD_MSB      15
`define LEVEL_LSB        8
`define LEVEL_MSB        15
`define SUB_LSB          4
`define SUB_MSB          7
`define FN_SPECIAL       4'h0
`define FN_CH_FIRST      4'h1
`define FN_CH_LAST       4'hC
`define FN_SER_TO_PAR    4'hD
`define FN_PAR_TO_SER    4'hE
`define FN_PIN_DIR       4'hF
`define SUB_ALL_LEVEL    4'hC
`define SUB_HIZ          4'hD
`define SUB_RESET        4'hE
`define SUB_CH_HIZ       4'h1
`define CH_HIZ_FIRST     4
`define DAC_RST          8'h00
`define DIR_RST          12'h000
`define OUT_RST          12'h000
`endif

// >>> core/pair_buffer.v
// Two-entry valid/ready buffer for executed command words.
// Assumes a single clock domain and asynchronous active-low reset.
`default_nettype none
module pair_buffer #(
    parameter WIDTH = 16
) (
    input  wire             sys_clk,
    input  wire             rst_b,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] slot_reg [0:1];
    reg             rd_ptr_reg;
    reg             wr_ptr_reg;
    reg [1:0]       count_reg;
    wire            push;
    wire            pop;

    assign in_ready  = (count_reg != 2'h2);
    assign out_valid = (count_reg != 2'h0);
    assign out_data  = slot_reg[rd_ptr_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_ptr_reg  <= 1'b0;
            wr_ptr_reg  <= 1'b0;
            count_reg   <= 2'h0;
            slot_reg[0] <= {WIDTH{1'b0}};
            slot_reg[1] <= {WIDTH{1'b0}};
        end else begin
            if (push) begin
                slot_reg[wr_ptr_reg] <= in_data;
                wr_ptr_reg           <= ~wr_ptr_reg;
            end
            if (pop)
                rd_ptr_reg <= ~rd_ptr_reg;
            if (push && !pop)
                count_reg <= count_reg + 2'h1;
            else if (pop && !push)
                count_reg <= count_reg - 2'h1;
        end
    end
endmodule
`default_nettype wire

// >>> core/serial_dac_port.v
// Serial command port: frame capture, command execution, expander and D/A state.
// Assumes link pins asynchronous to sys_clk, link clock well below sys_clk/6.
`include "dac_port_defs.vh"
`default_nettype none
// Overview of operation
// - Chip select falling opens a frame; host sends sixteen bits meanwhile.
// - Chip select rising decodes and executes the held sixteen-bit command.
// - Channel command with sub field other than one updates the selected analog level at chip select rising.
// - Serial-to-parallel command updates output-enabled expander pins at rising edge.
// - Direction command loads direction register and applies pin directions then.
// - Parallel-to-serial command is accepted at frame end, arming next-frame capture.
// - Next chip select falling samples input-direction expander pins into payload bits.
// - Captured contents shift out one bit per shift clock falling edge.
// - Low four bits select special, channels one to twelve, expander, direction.
// - Serial input shifts in on each shift clock rising edge while selected.
// - Serial output is LSB first, changes on falling edges, released when deselected.
// - Direction bit zero makes a pin input; one makes it output.
module serial_dac_port #(
    parameter CHANNELS = 12,
    parameter DAC_W    = 8,
    parameter PINS     = 12
) (
    input  wire                      sys_clk,
    input  wire                      rst_b,
    input  wire                      cs_b_pin,
    input  wire                      shift_clk_pin,
    input  wire                      serial_in_pin,
    output reg                       serial_out,
    output wire                      serial_out_oe,
    input  wire [PINS-1:0]           expander_pins_in,
    output wire [PINS-1:0]           expander_pins_out,
    output wire [PINS-1:0]           expander_pins_oe,
    output wire [CHANNELS*DAC_W-1:0] analog_output_channel,
    output wire [CHANNELS-1:0]       analog_output_hiz,
    output wire [PINS-1:0]           pin_direction_register,
    output wire [`CNT_W-1:0]         frame_bit_count,
    output wire                      exec_stall
);
    reg  [2:0]            cs_sync_reg;
    reg  [2:0]            sck_sync_reg;
    reg  [2:0]            si_sync_reg;
    reg                   cs_b_reg;
    reg                   sck_reg;
    reg  [`FRAME_BITS-1:0] shift_reg;
    reg  [`CNT_W-1:0]     count_reg;
    reg                   armed_reg;
    reg  [PINS-1:0]       dir_reg;
    reg  [PINS-1:0]       out_reg;
    reg  [PINS-1:0]       pin_samp_reg [0:2];
    reg  [DAC_W-1:0]      level_reg [0:CHANNELS-1];
    reg  [CHANNELS-1:0]   hiz_reg;
    wire                  cs_now;
    wire                  sck_now;
    wire                  cs_fall;
    wire                  cs_rise;
    wire                  sck_rise;
    wire                  sck_fall;
    wire                  cmd_ready;
    wire                  cmd_valid;
    wire [`FRAME_BITS-1:0] cmd;
    wire [3:0]            fn;
    wire [3:0]            sub;
    wire [DAC_W-1:0]      level;
    integer               i;

    // Three-stage sync: change counts once stages two and three agree
    assign cs_now   = (cs_sync_reg[1] == cs_sync_reg[2]) ? cs_sync_reg[2] : cs_b_reg;
    assign sck_now  = (sck_sync_reg[1] == sck_sync_reg[2]) ? sck_sync_reg[2] : sck_reg;
    assign cs_fall  = cs_b_reg && !cs_now;
    assign cs_rise  = !cs_b_reg && cs_now;
    assign sck_rise = !cs_b_reg && !sck_reg && sck_now;
    assign sck_fall = !cs_b_reg && sck_reg && !sck_now;

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cs_sync_reg  <= 3'h7;
            sck_sync_reg <= 3'h0;
            si_sync_reg  <= 3'h0;
            cs_b_reg     <= 1'b1;
            sck_reg      <= 1'b0;
            pin_samp_reg[0] <= {PINS{1'b0}};
            pin_samp_reg[1] <= {PINS{1'b0}};
            pin_samp_reg[2] <= {PINS{1'b0}};
        end else begin
            cs_sync_reg  <= {cs_sync_reg[1:0], cs_b_pin};
            sck_sync_reg <= {sck_sync_reg[1:0], shift_clk_pin};
            si_sync_reg  <= {si_sync_reg[1:0], serial_in_pin};
            cs_b_reg     <= cs_now;
            sck_reg      <= sck_now;
            pin_samp_reg[0] <= expander_pins_in;
            pin_samp_reg[1] <= pin_samp_reg[0];
            pin_samp_reg[2] <= pin_samp_reg[1];
        end
    end

    // Frame shifter and serial output
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            shift_reg  <= {`FRAME_BITS{1'b0}};
            count_reg  <= {`CNT_W{1'b0}};
            armed_reg  <= 1'b0;
            serial_out <= 1'b0;
        end else begin
            if (cs_fall) begin
                count_reg <= {`CNT_W{1'b0}};
                if (armed_reg) begin
                    // Pins driven by us (direction bit one) read as zero
                    shift_reg[`PAYLOAD_MSB:`PAYLOAD_LSB] <=
                        pin_samp_reg[2] & ~dir_reg;
                    armed_reg <= 1'b0;
                end
            end else if (sck_rise) begin
                shift_reg <= {si_sync_reg[2], shift_reg[`FRAME_BITS-1:1]};
                if (count_reg != `FRAME_BITS)
                    count_reg <= count_reg + 1'b1;
            end else if (sck_fall) begin
                serial_out <= shift_reg[0];
            end
            if (cs_rise && cmd_ready)
                armed_reg <= (shift_reg[`FUNC_MSB:`FUNC_LSB] == `FN_PAR_TO_SER);
        end
    end

    assign serial_out_oe   = !cs_b_reg;
    assign frame_bit_count = count_reg;
    assign exec_stall      = !cmd_ready;

    // Executed frames pass the buffer so a busy apply stage loses none
    pair_buffer #(
        .WIDTH(`FRAME_BITS)
    ) u_cmd_buf (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .in_valid  (cs_rise),
        .in_ready  (cmd_ready),
        .in_data   (shift_reg),
        .out_valid (cmd_valid),
        .out_ready (1'b1),
        .out_data  (cmd)
    );

    assign fn    = cmd[`FUNC_MSB:`FUNC_LSB];
    assign sub   = cmd[`SUB_MSB:`SUB_LSB];
    assign level = cmd[`LEVEL_MSB:`LEVEL_LSB];

    // Command decode and apply
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            dir_reg <= `DIR_RST;
            out_reg <= `OUT_RST;
            hiz_reg <= {CHANNELS{1'b0}};
            for (i = 0; i < CHANNELS; i = i + 1)
                level_reg[i] <= `DAC_RST;
        end else if (cmd_valid) begin
            case (fn)
                `FN_SPECIAL: begin
                    if (sub == `SUB_ALL_LEVEL) begin
                        for (i = 0; i < CHANNELS; i = i + 1) begin
                            level_reg[i] <= level;
                            hiz_reg[i]   <= 1'b0;
                        end
                    end else if (sub == `SUB_HIZ) begin
                        for (i = `CH_HIZ_FIRST; i < CHANNELS; i = i + 1)
                            hiz_reg[i] <= 1'b1;
                    end else if (sub == `SUB_RESET) begin
                        dir_reg <= `DIR_RST;
                        hiz_reg <= {CHANNELS{1'b0}};
                        for (i = 0; i < CHANNELS; i = i + 1)
                            level_reg[i] <= `DAC_RST;
                    end
                end
                `FN_SER_TO_PAR: out_reg <= cmd[`PAYLOAD_MSB:`PAYLOAD_LSB];
                `FN_PAR_TO_SER: ;
                `FN_PIN_DIR:    dir_reg <= cmd[`PAYLOAD_MSB:`PAYLOAD_LSB];
                default: begin
                    for (i = 0; i < CHANNELS; i = i + 1) begin
                        if (fn == i + 1) begin
                            if (sub == `SUB_CH_HIZ) begin
                                if (i >= `CH_HIZ_FIRST)
                                    hiz_reg[i] <= 1'b1;
                            end else begin
                                level_reg[i] <= level;
                                hiz_reg[i]   <= 1'b0;
                            end
                        end
                    end
                end
            endcase
        end
    end

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g = g + 1) begin : g_ch
            assign analog_output_channel[g*DAC_W +: DAC_W] = level_reg[g];
        end
    endgenerate

    assign analog_output_hiz      = hiz_reg;
    assign pin_direction_register = dir_reg;
    assign expander_pins_oe       = dir_reg;
    assign expander_pins_out      = out_reg & dir_reg;
endmodule
`default_nettype wire

// >>> verif/serial_dac_port_asserts.sv
// Checker on the serial command port's top-level ports.
// Assumes the bench host keeps chip select high between frames.
`default_nettype none
module serial_dac_port_asserts #(
    parameter CHANNELS = 12,
    parameter DAC_W    = 8,
    parameter PINS     = 12
) (
    input wire logic                      sys_clk,
    input wire logic                      rst_b,
    input wire logic                      cs_b_pin,
    input wire logic                      serial_out_oe,
    input wire logic [PINS-1:0]           expander_pins_out,
    input wire logic [PINS-1:0]           expander_pins_oe,
    input wire logic [CHANNELS*DAC_W-1:0] analog_output_channel,
    input wire logic [PINS-1:0]           pin_direction_register,
    input wire logic [4:0]                frame_bit_count
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    a_oe_is_dir: assert property (expander_pins_oe == pin_direction_register)
        else $error("pin enable differs from direction");
    a_out_masked: assert property ((expander_pins_out & ~expander_pins_oe) == '0)
        else $error("input pin shows output level");
    a_so_on: assert property (!cs_b_pin [*6] |-> serial_out_oe)
        else $error("serial out not driven in frame");
    a_so_off: assert property (cs_b_pin [*6] |-> !serial_out_oe)
        else $error("serial out driven while deselected");
    a_dir_hold: assert property (!cs_b_pin [*8] |=> $stable(pin_direction_register))
        else $error("direction changed inside frame");
    a_dac_hold: assert property (!cs_b_pin [*8] |=> $stable(analog_output_channel))
        else $error("level changed inside frame");
    a_pins_hold: assert property (!cs_b_pin [*8] |=> $stable(expander_pins_out))
        else $error("pins changed inside frame");
    a_cnt_step: assert property (!cs_b_pin [*8] |=>
        frame_bit_count - $past(frame_bit_count) <= 32'd1)
        else $error("bit count jumped");
    a_cnt_full: assert property ($rose(cs_b_pin) |-> frame_bit_count == 5'd16)
        else $error("frame closed without sixteen bits");
endmodule
bind serial_dac_port serial_dac_port_asserts #(.CHANNELS(CHANNELS), .DAC_W(DAC_W), .PINS(PINS))
    i_serial_dac_port_asserts (.sys_clk, .rst_b, .cs_b_pin, .serial_out_oe,
    .expander_pins_out, .expander_pins_oe, .analog_output_channel,
    .pin_direction_register, .frame_bit_count);
`default_nettype wire

// >>> verif/host_model.sv
// Host side of the chip-select serial link: sends frames, collects serial out.
// Assumes sys_clk at 40 MHz; link clock period 200 ns.
`default_nettype none
module host_model (
    input  wire logic sys_clk,
    output var logic  cs_b_pin,
    output var logic  shift_clk_pin,
    output var logic  serial_in_pin,
    input  wire logic serial_out,
    input  wire logic serial_out_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cs_b_pin = 1'b1;
        shift_clk_pin = 1'b0;
        serial_in_pin = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask
    // Sixteen clocks per frame, bit 0 first
    task automatic frame(input logic [15:0] w, output logic [15:0] r);
        cs_b_pin = 1'b0;
        for (int i = 0; i < 16; i++) begin
            tick(2);
            serial_in_pin = w[i];
            tick(2);
            if (i > 0) r[i-1] = serial_out_oe ? serial_out : 1'bx;
            shift_clk_pin = 1'b1;
            tick(4);
            shift_clk_pin = 1'b0;
        end
        tick(4);
        r[15] = serial_out_oe ? serial_out : 1'bx;
        cs_b_pin = 1'b1;
        tick(10);
    endtask
endmodule
`default_nettype wire

// >>> verif/serial_dac_expander_command_port_tb.sv
// Self-checking bench for the serial D/A and expander command port.
// Assumes host_model and the checker bind are compiled alongside.
`default_nettype none
module serial_dac_expander_command_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk, rst_b, cs_b_pin, shift_clk_pin, serial_in_pin, serial_out, so_oe;
    logic [11:0] pins_in, pins_out, pins_oe, dir, hiz, hizv;
    logic [4:0]  fbc;
    logic        stall;
    logic [95:0] aout;
    logic [15:0] r;
    int          mismatches, num_checks, lvl[12], dirv, outv, v;
    serial_dac_port i_serial_dac_port (.sys_clk(sys_clk), .rst_b(rst_b),
        .cs_b_pin(cs_b_pin), .shift_clk_pin(shift_clk_pin), .serial_in_pin(serial_in_pin),
        .serial_out(serial_out), .serial_out_oe(so_oe), .expander_pins_in(pins_in),
        .expander_pins_out(pins_out), .expander_pins_oe(pins_oe),
        .analog_output_channel(aout), .analog_output_hiz(hiz), .pin_direction_register(dir),
        .frame_bit_count(fbc), .exec_stall(stall));
    host_model i_host_model (.sys_clk(sys_clk), .cs_b_pin(cs_b_pin),
        .shift_clk_pin(shift_clk_pin), .serial_in_pin(serial_in_pin),
        .serial_out(serial_out), .serial_out_oe(so_oe));
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [95:0] g, input logic [95:0] e);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic check_state();
        logic [95:0] e;
        for (int i = 0; i < 12; i++) e[8*i+:8] = lvl[i][7:0];
        chk(aout, e);
        chk(96'(dir), 96'(dirv[11:0]));
        chk(96'(pins_out), 96'(outv[11:0] & dirv[11:0]));
        chk(96'(hiz), 96'(hizv));
    endtask
    task automatic send(input logic [15:0] w);
        i_host_model.frame(w, r);
        chk(96'(fbc), 96'(5'h10));
        chk(96'(stall), 96'(1'h0));
    endtask
    initial begin
        #400us;
        mismatches++;
        end_of_test();
    end
    initial begin
        rst_b = 1'b0;
        pins_in = 12'h000;
        {mismatches, num_checks, dirv, outv} = '0;
        lvl = '{default: 0};
        hizv = 12'h000;
        v = $urandom(32'hD71E);
        repeat (8) @(posedge sys_clk);
        #2 rst_b = 1'b1;
        check_state();
        for (int c = 1; c <= 12; c++) begin
            v = $urandom & 255;
            send({v[7:0], 4'h0, c[3:0]});
            lvl[c-1] = v;
            check_state();
        end
        $display("channel test done");
        repeat (3) begin
            v = $urandom;
            send({v[11:0], 4'hF});
            dirv = v & 12'hFFF;
            v = $urandom;
            send({v[11:0], 4'hD});
            outv = v & 12'hFFF;
            check_state();
            pins_in = 12'($urandom);
            send(16'h000E);
            send(16'h0000);
            chk(96'(r[14:3]), 96'(pins_in & ~dirv[11:0]));
            check_state();
        end
        $display("expander test done");
        for (int c = 4; c <= 6; c++) begin
            send({8'h00, 4'h1, c[3:0]});
            if (c > 4) hizv[c-1] = 1'b1;
            check_state();
        end
        send(16'h00D0);
        hizv = 12'hFF0;
        check_state();
        v = $urandom & 255;
        send({v[7:0], 8'h0C});
        lvl[11] = v;
        hizv[11] = 1'b0;
        check_state();
        v = $urandom & 255;
        send({v[7:0], 8'hC0});
        foreach (lvl[i]) lvl[i] = v;
        hizv = 12'h000;
        check_state();
        send(16'h00E0);
        dirv = 0;
        lvl = '{default: 0};
        check_state();
        $display("special test done");
        end_of_test();
    end
endmodule
`default_nettype wire
